// ---- rtl/acs_host_cmd.sv ----
// host command handshake, mailbox and frame pipeline of the codec dsp
//
// Contract
// RQ1 - no host access during ten ms initialisation
// RQ2 - host polls line status, then reads code
// RQ3 - interrupt flag shows pending regardless of mask
// RQ4 - version code puts version, clears busy
// RQ5 - host zeroes comm registers before reset
// RQ6 - soft reset clears busy, posts ack code
// RQ7 - host clearing device busy is optional
// RQ8 - soft reset reruns init, firmware registers only
// RQ9 - control write loads block, posts ack
// RQ10 - status read fills mailbox, posts ack
// RQ11 - status done code clears host busy
// RQ12 - new settings apply from next frame
// RQ13 - three frame pipeline before status shows
// RQ14 - host holds neutral three frames first
// RQ15 - listed fields change on the fly
// RQ16 - device starts in neutral mode
// RQ17 - nine byte block with fixed layout
// RQ18 - offline mode counts exchanged frames instead
// RQ19 - control word resets to c1, low 0001
// RQ20 - four bit encoder and decoder mode codes
// RQ21 - no new request while host busy
`timescale 1ns/1ps
module acs_host_cmd #(
    parameter int unsigned INIT_CYCLES = acs_pkg::INIT_CYCLES,
    parameter int unsigned FRAME_CYCLES = acs_pkg::FRAME_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic host_cs_n,
    input wire logic host_wr_n,
    input wire logic host_rd_n,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_data_in,
    input wire logic host_frame_strobe,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    output logic host_int_n,
    output logic init_busy,
    output logic [7:0] active_mode
);
    typedef enum logic {ACS_INIT, ACS_IDLE} acs_state_t;

    function automatic logic [71:0] acs_clean(input logic [71:0] b);
        acs_clean = (b & acs_pkg::BLK_KEEP) | acs_pkg::BLK_FIXED;
    endfunction : acs_clean

    function automatic logic acs_in_mbox(input logic [7:0] a);
        logic [7:0] off;
        off = a - acs_pkg::OFS_MBOX;
        acs_in_mbox = off < acs_pkg::BLK_WORDS;
    endfunction : acs_in_mbox

    logic [19:0] pin_raw;
    logic [19:0] pin_s;
    logic [19:0] pin_d_r;
    logic [7:0] mbox_r [9];
    logic [71:0] mbox_blk;
    logic [71:0] new_blk;
    logic [7:0] host_code_r;
    logic [7:0] dsp_code_r;
    logic [7:0] comm_a_r;
    logic [7:0] comm_b_r;
    logic host_busy_r;
    logic dsp_busy_r;
    logic mask_r;
    logic [71:0] pend_r;
    logic [71:0] act_r;
    logic [71:0] pipe_r;
    logic [71:0] stat_r;
    logic pend_vld_r;
    acs_state_t st_r;
    logic init_r;
    logic [7:0] data_out_r;
    logic data_oe_r;
    logic int_n_r;

    assign pin_raw = {host_frame_strobe, host_cs_n, host_wr_n, host_rd_n,
                      host_addr, host_data_in};

    acs_sync #(.W(acs_pkg::PIN_W), .IDLE(acs_pkg::PIN_IDLE)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .d(pin_raw),
        .q(pin_s)
    );

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_d_r <= acs_pkg::PIN_IDLE;
        end else begin
            pin_d_r <= pin_s;
        end
    end

    // a write completes on the rising edge of the write strobe
    wire wr_fire = pin_s[acs_pkg::PIN_WR_N] & ~pin_d_r[acs_pkg::PIN_WR_N]
                   & ~pin_d_r[acs_pkg::PIN_CS_N];
    wire [7:0] wr_addr = pin_d_r[15:8];
    wire [7:0] wr_data = pin_d_r[7:0];
    wire [7:0] wr_off = wr_addr - acs_pkg::OFS_MBOX;
    wire [7:0] rd_addr = pin_s[15:8];
    wire [7:0] rd_off = rd_addr - acs_pkg::OFS_MBOX;
    wire rd_act = ~pin_s[acs_pkg::PIN_RD_N] & ~pin_s[acs_pkg::PIN_CS_N];
    wire frame_rise = pin_s[acs_pkg::PIN_FRAME] & ~pin_d_r[acs_pkg::PIN_FRAME];

    // RQ1 writes ignored while initialising
    wire wr_ok = wr_fire & (st_r == ACS_IDLE);
    // RQ21 a new code is dropped while the previous one is pending
    wire wr_cmd = wr_ok & (wr_addr == acs_pkg::OFS_H2D) & ~host_busy_r;
    wire wr_mbox = wr_ok & acs_in_mbox(wr_addr);
    wire wr_ca = wr_ok & (wr_addr == acs_pkg::OFS_COMM_A);
    wire wr_cb = wr_ok & (wr_addr == acs_pkg::OFS_COMM_B);
    wire wr_mask = wr_ok & (wr_addr == acs_pkg::OFS_MASK);
    wire dsp_clr = wr_ok & (wr_addr == acs_pkg::OFS_LINE_STAT)
                   & wr_data[acs_pkg::ST_DSP_BUSY];

    // command decode: one code is served the cycle after it lands
    wire cmd_go = (st_r == ACS_IDLE) & host_busy_r;
    wire is_ver = cmd_go & (host_code_r == acs_pkg::CMD_VERSION);
    wire is_srst = cmd_go & (host_code_r == acs_pkg::CMD_SOFT_RESET);
    wire is_cwr = cmd_go & (host_code_r == acs_pkg::CMD_CTRL_WRITE);
    wire is_srd = cmd_go & (host_code_r == acs_pkg::CMD_STAT_READ);
    wire is_sack = cmd_go & (host_code_r == acs_pkg::CMD_STAT_DONE);
    wire dsp_post = is_srst | is_cwr | is_srd;
    wire [7:0] dsp_code_nxt = is_srst ? acs_pkg::ACK_SOFT_RESET :
                              is_cwr ? acs_pkg::ACK_CTRL_WRITE :
                              acs_pkg::ACK_STAT_READ;

    // RQ18 with all data on the host, frames are counted by the host
    wire offline = act_r[acs_pkg::INTERFACE_SELECT_HI:acs_pkg::INTERFACE_SELECT_LO]
                   == acs_pkg::INTERFACE_SELECT_ALL_HOST;
    wire timer_tick;
    wire init_tick;
    wire frame_tick = offline ? frame_rise : timer_tick;

    acs_timer #(.CYCLES(FRAME_CYCLES)) u_frame (
        .clk_sys(clk_sys),
        .rst(rst),
        .restart(1'b0),
        .run(1'b1),
        .tick(timer_tick)
    );

    // RQ8 init timer restarted by a soft reset
    acs_timer #(.CYCLES(INIT_CYCLES)) u_init (
        .clk_sys(clk_sys),
        .rst(rst),
        .restart(is_srst),
        .run(st_r == ACS_INIT),
        .tick(init_tick)
    );

    wire acs_state_t st_nxt = is_srst ? ACS_INIT :
                              init_tick ? ACS_IDLE : st_r;

    always_comb begin
        for (int i = 0; i < 9; i++) begin
            mbox_blk[i*8 +: 8] = mbox_r[i];
        end
    end

    // RQ17 fixed bits and the zero byte are forced on every block
    assign new_blk = acs_clean(mbox_blk);

    // RQ15 exempt fields take effect at once
    wire [71:0] fly_blk = (act_r & ~acs_pkg::BLK_EXEMPT)
                          | (new_blk & acs_pkg::BLK_EXEMPT);
    // RQ12 the rest waits for the next frame boundary
    wire [71:0] act_nxt = is_cwr ? fly_blk :
                          (frame_tick & pend_vld_r) ? pend_r : act_r;
    wire pend_vld_nxt = is_cwr | (pend_vld_r & ~frame_tick);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= ACS_INIT;
            init_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            init_r <= st_nxt == ACS_INIT;
        end
    end

    // RQ9 RQ10 RQ11 RQ4 host busy cleared as each code is served
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            host_code_r <= 8'h00;
            host_busy_r <= 1'b0;
        end else if (wr_cmd) begin
            host_code_r <= wr_data;
            host_busy_r <= 1'b1;
        end else if (cmd_go) begin
            host_busy_r <= 1'b0;
        end
    end

    // RQ6 ack code posted and device busy raised
    // RQ7 a post in the same cycle as a host clear wins
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dsp_code_r <= 8'h00;
            dsp_busy_r <= 1'b0;
        end else begin
            dsp_busy_r <= dsp_post | (dsp_busy_r & ~dsp_clr);
            if (dsp_post) begin
                dsp_code_r <= dsp_code_nxt;
            end
        end
    end

    // RQ4 version lands in the first comm register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            comm_a_r <= 8'h00;
            comm_b_r <= 8'h00;
            mask_r <= acs_pkg::MASK_RESET;
        end else begin
            if (is_ver) begin
                comm_a_r <= acs_pkg::FW_VERSION;
            end else if (wr_ca) begin
                comm_a_r <= wr_data;
            end
            if (wr_cb) begin
                comm_b_r <= wr_data;
            end
            if (wr_mask) begin
                mask_r <= wr_data[0];
            end
        end
    end

    // RQ10 status copy into the mailbox beats a host write
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 9; i++) begin
                mbox_r[i] <= 8'h00;
            end
        end else if (is_srd) begin
            for (int i = 0; i < 9; i++) begin
                mbox_r[i] <= stat_r[i*8 +: 8];
            end
        end else if (wr_mbox) begin
            mbox_r[wr_off[3:0]] <= wr_data;
        end
    end

    // RQ16 RQ19 RQ8 firmware registers back to defaults on any reset
    // RQ13 input, coding and output stages shift once per frame
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pend_r <= acs_pkg::BLK_RESET;
            act_r <= acs_pkg::BLK_RESET;
            pipe_r <= acs_pkg::BLK_RESET;
            stat_r <= acs_pkg::BLK_RESET;
            pend_vld_r <= 1'b0;
        end else if (is_srst) begin
            pend_r <= acs_pkg::BLK_RESET;
            act_r <= acs_pkg::BLK_RESET;
            pipe_r <= acs_pkg::BLK_RESET;
            stat_r <= acs_pkg::BLK_RESET;
            pend_vld_r <= 1'b0;
        end else begin
            act_r <= act_nxt;
            pend_vld_r <= pend_vld_nxt;
            if (is_cwr) begin
                pend_r <= new_blk;
            end
            if (frame_tick) begin
                pipe_r <= act_r;
                stat_r <= pipe_r;
            end
        end
    end

    // RQ3 flag follows the pending interrupt, mask only gates the line
    wire [7:0] line_stat = {4'h0, init_r, dsp_busy_r, host_busy_r, dsp_busy_r};
    wire [7:0] rd_val =
        acs_in_mbox(rd_addr) ? mbox_r[rd_off[3:0]] :
        (rd_addr == acs_pkg::OFS_H2D) ? host_code_r :
        (rd_addr == acs_pkg::OFS_D2H) ? dsp_code_r :
        (rd_addr == acs_pkg::OFS_COMM_A) ? comm_a_r :
        (rd_addr == acs_pkg::OFS_COMM_B) ? comm_b_r :
        (rd_addr == acs_pkg::OFS_MASK) ? {7'h00, mask_r} :
        (rd_addr == acs_pkg::OFS_LINE_STAT) ? line_stat : 8'h00;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            data_out_r <= 8'h00;
            data_oe_r <= 1'b0;
            int_n_r <= 1'b1;
        end else begin
            data_out_r <= rd_val;
            data_oe_r <= rd_act;
            int_n_r <= ~(dsp_busy_r & mask_r);
        end
    end

    assign host_data_out = data_out_r;
    assign host_data_oe = data_oe_r;
    assign host_int_n = int_n_r;
    assign init_busy = init_r;
    // RQ20 encoder nibble high, decoder nibble low
    assign active_mode = act_r[acs_pkg::W_MODE*8 +: 8];

    // helper: length of the initialisation phase
    logic [31:0] init_len_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            init_len_r <= 32'h0;
        end else if (st_r == ACS_INIT) begin
            init_len_r <= init_len_r + 32'h1;
        end else begin
            init_len_r <= 32'h0;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence tick_s;
        frame_tick && !is_srst;
    endsequence

    sequence reset_post_s;
        dsp_busy_r && dsp_code_r == acs_pkg::ACK_SOFT_RESET;
    endsequence

    init_length_a: assert property ( // RQ1
        (st_r == ACS_INIT && init_tick)
            |-> init_len_r == 32'(INIT_CYCLES - 1))
        else $error("init phase has wrong length");
    version_reply_a: assert property ( // RQ4
        is_ver |=> comm_a_r == acs_pkg::FW_VERSION && !host_busy_r)
        else $error("version not posted");
    reset_ack_a: assert property ( // RQ6
        is_srst |=> reset_post_s ##0 (st_r == ACS_INIT && !host_busy_r)
            ##1 init_r)
        else $error("soft reset not acknowledged");
    reset_block_a: assert property ( // RQ19
        is_srst |=> act_r[7:0] == acs_pkg::CTRL_RESET
            && active_mode == {acs_pkg::MODE_NEUTRAL, acs_pkg::MODE_NEUTRAL})
        else $error("block not back at defaults");
    ctrl_ack_a: assert property ( // RQ9
        is_cwr |=> dsp_code_r == acs_pkg::ACK_CTRL_WRITE && dsp_busy_r
            && pend_r == $past(new_blk))
        else $error("control write not taken");
    stat_ack_a: assert property ( // RQ10
        is_srd |=> dsp_code_r == acs_pkg::ACK_STAT_READ
            && mbox_r[acs_pkg::W_MODE] == $past(stat_r[39:32]))
        else $error("status read not served");
    stat_done_a: assert property ( // RQ11
        is_sack |=> !host_busy_r && $stable(dsp_code_r))
        else $error("status done not handled");
    flag_unmasked_a: assert property ( // RQ3
        dsp_busy_r |-> line_stat[acs_pkg::ST_FLAG] ##1 (host_int_n
            != $past(mask_r)))
        else $error("flag hidden by mask");
    next_frame_a: assert property ( // RQ12
        (tick_s and (pend_vld_r && !is_cwr)) |=> act_r == $past(pend_r))
        else $error("settings not applied at frame");
    pipe_stage_a: assert property ( // RQ13
        tick_s |=> stat_r == $past(pipe_r) && pipe_r == $past(act_r))
        else $error("pipeline did not shift");
    on_fly_a: assert property ( // RQ15
        is_cwr |=> (act_r & acs_pkg::BLK_EXEMPT)
            == ($past(new_blk) & acs_pkg::BLK_EXEMPT))
        else $error("exempt field not applied at once");
    fixed_bits_a: assert property ( // RQ17
        (act_r & ~acs_pkg::BLK_KEEP) == acs_pkg::BLK_FIXED
            && (stat_r & ~acs_pkg::BLK_KEEP) == acs_pkg::BLK_FIXED)
        else $error("fixed block bits disturbed");
endmodule : acs_host_cmd

// ---- rtl/acs_sync.sv ----
// two flip-flop synchroniser for a vector of pins
`timescale 1ns/1ps
module acs_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] IDLE = '0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_r <= IDLE;
            q_r <= IDLE;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule : acs_sync

// ---- rtl/acs_timer.sv ----
// cycle timer that pulses once every CYCLES enabled cycles
`timescale 1ns/1ps
module acs_timer #(
    parameter int unsigned CYCLES = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic restart,
    input wire logic run,
    output logic tick
);
    logic [31:0] cnt_r;
    logic at_end;

    assign at_end = cnt_r == 32'(CYCLES - 1);
    assign tick = run & ~restart & at_end;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_r <= 32'h0;
        end else if (restart || tick) begin
            cnt_r <= 32'h0;
        end else if (run) begin
            cnt_r <= cnt_r + 32'h1;
        end
    end
endmodule : acs_timer

// ---- shared/acs_pkg.sv ----
// constants for the host command handshake block
package acs_pkg;
    // host register offsets
    localparam logic [7:0] OFS_MBOX = 8'h40;
    localparam logic [7:0] OFS_H2D = 8'h50;
    localparam logic [7:0] OFS_D2H = 8'h58;
    localparam logic [7:0] OFS_COMM_A = 8'h60;
    localparam logic [7:0] OFS_COMM_B = 8'h61;
    localparam logic [7:0] OFS_MASK = 8'h74;
    localparam logic [7:0] OFS_LINE_STAT = 8'h75;
    // interrupt codes
    localparam logic [7:0] CMD_SOFT_RESET = 8'h12;
    localparam logic [7:0] ACK_SOFT_RESET = 8'h13;
    localparam logic [7:0] CMD_VERSION = 8'h19;
    localparam logic [7:0] CMD_CTRL_WRITE = 8'h31;
    localparam logic [7:0] ACK_CTRL_WRITE = 8'h32;
    localparam logic [7:0] CMD_STAT_READ = 8'h33;
    localparam logic [7:0] ACK_STAT_READ = 8'h34;
    localparam logic [7:0] CMD_STAT_DONE = 8'h35;
    // firmware version, value is arbitrary
    localparam logic [7:0] FW_VERSION = 8'h5a;
    // line status bit positions
    localparam int ST_FLAG = 0;
    localparam int ST_HOST_BUSY = 1;
    localparam int ST_DSP_BUSY = 2;
    localparam int ST_INIT = 3;
    localparam logic MASK_RESET = 1'b1;
    // control and status block: nine bytes, word 0 in the low byte
    localparam logic [7:0] BLK_WORDS = 8'h09;
    localparam int BLK_W = 72;
    localparam int W_CTRL = 0;
    localparam int W_MODE = 4;
    localparam int INTERFACE_SELECT_HI = 6;
    localparam int INTERFACE_SELECT_LO = 5;
    localparam logic [1:0] INTERFACE_SELECT_ALL_HOST = 2'b00;
    localparam logic [71:0] BLK_RESET = 72'h000000000000001ac1;
    localparam logic [71:0] BLK_KEEP = 72'hffff9f7fff800005f0;
    localparam logic [71:0] BLK_FIXED = 72'h000000000000001a01;
    localparam logic [71:0] BLK_EXEMPT = 72'hffff1f030000000500;
    localparam logic [7:0] CTRL_RESET = 8'hc1;
    // codec mode codes, one nibble each for encoder and decoder
    localparam logic [3:0] MODE_NEUTRAL = 4'h0;
    localparam logic [3:0] MODE_LINEAR = 4'h1;
    localparam logic [3:0] MODE_A_LAW = 4'h2;
    localparam logic [3:0] MODE_MU_LAW = 4'h3;
    localparam logic [3:0] MODE_WIDEBAND = 4'h4;
    localparam logic [3:0] MODE_LD_CELP = 4'h5;
    // synchronised pin vector layout
    localparam int PIN_W = 20;
    localparam int PIN_FRAME = 19;
    localparam int PIN_CS_N = 18;
    localparam int PIN_WR_N = 17;
    localparam int PIN_RD_N = 16;
    localparam logic [19:0] PIN_IDLE = 20'h70000;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int INIT_TIME_MS = 10;
    localparam int FRAME_TIME_MS = 10;
    localparam int INIT_CYCLES = INIT_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int FRAME_CYCLES = FRAME_TIME_MS * 1000000 / CLK_PERIOD_NS;
endpackage : acs_pkg

// ---- sim/acs_host_cmd_tb.sv ----
// self-checking bench for the host command handshake block
`timescale 1ns/1ps
module acs_host_cmd_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic host_frame_strobe = 1'b0;
    logic host_cs_n;
    logic host_wr_n;
    logic host_rd_n;
    logic [7:0] host_addr;
    logic [7:0] host_data_in;
    logic [7:0] host_data_out;
    logic [7:0] active_mode;
    logic host_data_oe;
    logic host_int_n;
    logic init_busy;
    int failures = 0;
    int n_checks = 0;
    logic [31:0] seed = 32'h62;
    logic [7:0] rv;
    logic [7:0] m2;
    logic [7:0] blk [9];

    always #5 clk_sys = ~clk_sys;

    acs_host_cmd #(.INIT_CYCLES(20), .FRAME_CYCLES(10)) i_dut (
        .clk_sys(clk_sys), .rst(rst), .host_cs_n(host_cs_n),
        .host_wr_n(host_wr_n), .host_rd_n(host_rd_n),
        .host_addr(host_addr), .host_data_in(host_data_in),
        .host_frame_strobe(host_frame_strobe),
        .host_data_out(host_data_out), .host_data_oe(host_data_oe),
        .host_int_n(host_int_n), .init_busy(init_busy),
        .active_mode(active_mode)
    );

    acs_host_model i_host (
        .clk_sys(clk_sys), .host_cs_n(host_cs_n), .host_wr_n(host_wr_n),
        .host_rd_n(host_rd_n), .host_addr(host_addr),
        .host_data_in(host_data_in), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // a block word with fixed bits set and only legal codes
    function automatic logic [7:0] legal(input int i, input logic [7:0] r);
        case (i)
            0: return 8'hc1;
            1: return 8'h1a | (r & 8'h05);
            2: return 8'h00;
            3: return r & 8'h80;
            4: return {4'(r[7:4] % 6), 4'(r[3:0] % 6)};
            5: return r & 8'h7f;
            6: return r & 8'h9f;
            default: return r;
        endcase
    endfunction : legal

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // no access until initialisation has ended
    task automatic wait_init();
        for (int i = 0; i < 100 && init_busy !== 1'b0; i++) begin
            @(posedge clk_sys);
        end
        check({7'h0, init_busy}, 8'h00);
        repeat (3) @(posedge clk_sys);
    endtask : wait_init

    task automatic put_blk(input logic fresh, input logic [7:0] w0,
                           input logic [7:0] m);
        for (int i = 0; i < 9 && fresh; i++) begin
            seed = xs(seed);
            blk[i] = legal(i, seed[7:0]);
        end
        blk[0] = w0;
        blk[4] = m;
        for (int i = 0; i < 9; i++) begin
            i_host.wr(acs_pkg::OFS_MBOX + 8'(i), blk[i]);
        end
        i_host.code(acs_pkg::CMD_CTRL_WRITE);
        i_host.poll(acs_pkg::ST_FLAG, 1'b1);
        i_host.rd(acs_pkg::OFS_D2H, rv);
        check(rv, acs_pkg::ACK_CTRL_WRITE);
    endtask : put_blk

    task automatic stat_rd(input logic dflt);
        logic [7:0] e;
        i_host.code(acs_pkg::CMD_STAT_READ);
        i_host.poll(acs_pkg::ST_FLAG, 1'b1);
        i_host.rd(acs_pkg::OFS_D2H, rv);
        check(rv, acs_pkg::ACK_STAT_READ);
        for (int i = 0; i < 9; i++) begin
            e = dflt ? ((i == 0) ? 8'hc1 : (i == 1) ? 8'h1a : 8'h00) : blk[i];
            i_host.rd(acs_pkg::OFS_MBOX + 8'(i), rv);
            check(rv, e);
        end
        i_host.wr(acs_pkg::OFS_H2D, acs_pkg::CMD_STAT_DONE);
        i_host.rd(acs_pkg::OFS_LINE_STAT, rv);
        check({7'h0, rv[acs_pkg::ST_HOST_BUSY]}, 8'h00);
    endtask : stat_rd

    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        results();
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        check({7'h0, init_busy}, 8'h01);
        check(active_mode, 8'h00);
        rst <= 1'b0;
        // mask write lands inside initialisation and must be dropped
        i_host.wr(acs_pkg::OFS_MASK, 8'h00);
        wait_init();
        i_host.rd(8'h10, rv);
        check(rv, 8'h00);
        stat_rd(1'b1);
        i_host.code(acs_pkg::CMD_VERSION);
        i_host.rd(acs_pkg::OFS_COMM_A, rv);
        check(rv, acs_pkg::FW_VERSION);
        check({7'h0, i_host.oe_seen}, 8'h01);
        check({7'h0, host_data_oe}, 8'h00);
        // block may be written straight after initialisation
        put_blk(1'b1, 8'hc1, legal(4, 8'h23));
        check({7'h0, host_int_n}, 8'h00);
        repeat (12) @(posedge clk_sys);
        check(active_mode, blk[4]);
        i_host.wr(acs_pkg::OFS_MASK, 8'h00);
        check({7'h0, host_int_n}, 8'h01);
        i_host.rd(acs_pkg::OFS_LINE_STAT, rv);
        check({7'h0, rv[acs_pkg::ST_FLAG]}, 8'h01);
        i_host.wr(acs_pkg::OFS_MASK, 8'h01);
        i_host.wr(acs_pkg::OFS_LINE_STAT, 8'h04);
        i_host.rd(acs_pkg::OFS_LINE_STAT, rv);
        check({5'h0, rv[2:0]}, 8'h00);
        repeat (30) @(posedge clk_sys);
        stat_rd(1'b0);
        // hold neutral three frames before other changes
        put_blk(1'b0, 8'hc1, 8'h00);
        repeat (35) @(posedge clk_sys);
        seed = xs(seed);
        m2 = legal(4, seed[7:0] | 8'h11);
        put_blk(1'b1, 8'h01, m2);
        repeat (12) @(posedge clk_sys);
        check(active_mode, m2);
        put_blk(1'b0, 8'h01, 8'h00);
        repeat (30) @(posedge clk_sys);
        check(active_mode, m2);
        host_frame_strobe <= 1'b1;
        repeat (3) @(posedge clk_sys);
        host_frame_strobe <= 1'b0;
        repeat (5) @(posedge clk_sys);
        check(active_mode, 8'h00);
        // zero both comm registers before the reset code
        i_host.wr(acs_pkg::OFS_COMM_A, 8'h00);
        i_host.wr(acs_pkg::OFS_COMM_B, 8'h00);
        i_host.wr(acs_pkg::OFS_H2D, acs_pkg::CMD_SOFT_RESET);
        check({7'h0, init_busy}, 8'h01);
        wait_init();
        i_host.poll(acs_pkg::ST_FLAG, 1'b1);
        i_host.rd(acs_pkg::OFS_D2H, rv);
        check(rv, acs_pkg::ACK_SOFT_RESET);
        check({7'h0, host_int_n}, 8'h00);
        check(active_mode, 8'h00);
        // dsp busy left set, next handshake must still work
        i_host.code(acs_pkg::CMD_VERSION);
        i_host.rd(acs_pkg::OFS_COMM_A, rv);
        check(rv, acs_pkg::FW_VERSION);
        stat_rd(1'b1);
        check(8'(i_host.timeouts), 8'h00);
        results();
    end
endmodule : acs_host_cmd_tb

// ---- sim/acs_host_model.sv ----
// host processor model driving the parallel register pins
`timescale 1ns/1ps
module acs_host_model (
    input wire logic clk_sys,
    output logic host_cs_n,
    output logic host_wr_n,
    output logic host_rd_n,
    output logic [7:0] host_addr,
    output logic [7:0] host_data_in,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe
);
    int timeouts = 0;
    logic oe_seen = 1'b0;

    initial begin
        host_cs_n = 1'b1;
        host_wr_n = 1'b1;
        host_rd_n = 1'b1;
        host_addr = 8'h00;
        host_data_in = 8'hff;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    // pins stay stable four cycles either side of the write strobe rising
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_addr <= a;
        host_data_in <= d;
        host_cs_n <= 1'b0;
        cyc(4);
        host_wr_n <= 1'b0;
        cyc(4);
        host_wr_n <= 1'b1;
        cyc(4);
        host_cs_n <= 1'b1;
        // released bus shows the inverse of the last value
        host_data_in <= ~d;
        cyc(2);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        host_addr <= a;
        host_cs_n <= 1'b0;
        host_rd_n <= 1'b0;
        cyc(6);
        d = host_data_out;
        oe_seen = host_data_oe;
        host_rd_n <= 1'b1;
        host_cs_n <= 1'b1;
        cyc(5);
    endtask : rd

    // poll line status bits, not the ack code register
    task automatic poll(input int b, input logic v);
        logic [7:0] s;
        for (int i = 0; i < 40 && s[b] !== v; i++) begin
            rd(acs_pkg::OFS_LINE_STAT, s);
        end
        if (s[b] !== v) begin
            timeouts++;
        end
    endtask : poll

    // issue a code only once host busy reads zero
    task automatic code(input logic [7:0] c);
        poll(acs_pkg::ST_HOST_BUSY, 1'b0);
        wr(acs_pkg::OFS_H2D, c);
        poll(acs_pkg::ST_HOST_BUSY, 1'b0);
    endtask : code
endmodule : acs_host_model
